// [hw/fastlock_timer.sv]
`default_nettype none
module fastlock_timer (
    input wire logic clk,
    input wire logic reset,
    fastlock_timer_if.timer tif
);
    pump_ctrl_pkg::timer_state_t state_q, state_d;
    logic [pump_ctrl_pkg::CNT_W-1:0] count_q, count_d;
    wire last_tick = tif.tick && (count_q == 16'h0001);

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        if (tif.load) begin
            // A zero duration leaves the timer off rather than running forever.
            state_d = (tif.duration != 16'h0000) ? pump_ctrl_pkg::T_RUN : pump_ctrl_pkg::T_IDLE;
            count_d = tif.duration;
        end else begin
            unique case (state_q)
                pump_ctrl_pkg::T_RUN: begin
                    if (tif.tick) begin
                        count_d = count_q - 16'h0001;
                    end
                    if (last_tick) begin
                        state_d = pump_ctrl_pkg::T_IDLE;
                    end
                end
                pump_ctrl_pkg::T_IDLE: count_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= pump_ctrl_pkg::T_IDLE;
            count_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign tif.active = (state_q == pump_ctrl_pkg::T_RUN);
    assign tif.count = count_q;

    property p_load_arms;
        @(posedge clk) disable iff (reset)
        tif.load && tif.duration != 16'h0000 |=> tif.active && tif.count == $past(tif.duration);
    endproperty
    a_load_arms: assert property (p_load_arms) else $error("timer not armed by load");

    property p_zero_off;
        @(posedge clk) disable iff (reset)
        tif.load && tif.duration == 16'h0000 |=> !tif.active;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero duration started the timer");

    property p_decrement;
        @(posedge clk) disable iff (reset)
        tif.active && tif.tick && !tif.load |=> tif.count == $past(tif.count) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("timer did not step down");

    property p_hold;
        @(posedge clk) disable iff (reset)
        tif.active && !tif.tick && !tif.load |=> tif.active && $stable(tif.count);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved without a tick");
endmodule
`default_nettype wire

// [hw/fastlock_timer_if.sv]
`default_nettype none
interface fastlock_timer_if;
    logic load;
    logic [pump_ctrl_pkg::CNT_W-1:0] duration;
    logic tick;
    logic active;
    logic [pump_ctrl_pkg::CNT_W-1:0] count;
    modport ctrl (output load, output duration, output tick, input active, input count);
    modport timer (input load, input duration, input tick, output active, output count);
endinterface
`default_nettype wire

// [hw/pll_fastlock_pump_control.sv]
// How it works
// - The boost pump gain is driven only while the timer runs or a boost-flagged ramp runs; codes are n x 100 uA.
// - With the reference edge leading, the pump sources when polarity is 0 and sinks when it is 1.
// - While boosted, both divide values are multiplied by the slip factor: 0 off, 1 x2, 2 x4, 3 reserved.
// - Writing the feedback divider register starts the acceleration timer.
// - The timer value is 11 bits over two registers; 0 disables it and v gives v x 32 counts.
// - When the timer ends, unless a boost-flagged ramp runs, the normal gain returns and the divider scaling is removed.
`default_nettype none
module pll_fastlock_pump_control (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic PD_TICK,
    input wire logic RAMP_ACTIVE,
    input wire logic RAMP_BOOST_FLAG,
    input wire logic REF_LEADS,
    input wire logic FB_LEADS,
    output logic [4:0] PUMP_GAIN,
    output logic PUMP_SOURCE,
    output logic PUMP_SINK,
    output logic [17:0] REF_DIV_EFF,
    output logic [17:0] FB_DIV_EFF,
    output logic BOOST_ACTIVE
);
    logic [7:0] div_misc_control_q;
    logic [7:0] pump_gain_polarity_q;
    logic [7:0] boost_gain_timer_high_q;
    logic [7:0] boost_timer_low_q;
    logic [15:0] fb_div_q;
    logic [15:0] ref_div_q;
    logic wr_pend_q;
    logic rd_wait_q;
    logic [7:0] widx_q;
    logic [7:0] ridx_q;
    logic [31:0] hrdata_q;
    logic [4:0] pump_gain_q;
    logic source_q;
    logic sink_q;
    logic [17:0] ref_eff_q;
    logic [17:0] fb_eff_q;
    logic boost_q;

    fastlock_timer_if tif ();

    fastlock_timer u_timer (
        .clk(CLK_SYS),
        .reset(RESET),
        .tif(tif)
    );

    // Bus decode. Reads take one wait state so that hrdata can come from a flip-flop.
    wire accept = HSEL && HTRANS[1] && HREADY;
    wire in_map = (HADDR[31:10] == 22'h000000);
    wire [7:0] aidx = in_map ? HADDR[9:2] : 8'hFF;
    wire wr_fb = wr_pend_q && (widx_q == pump_ctrl_pkg::IDX_FB_DIV);
    wire wr_ref = wr_pend_q && (widx_q == pump_ctrl_pkg::IDX_REF_DIV);
    wire wr_misc = wr_pend_q && (widx_q == pump_ctrl_pkg::IDX_DIV_MISC);
    wire wr_gpol = wr_pend_q && (widx_q == pump_ctrl_pkg::IDX_GAIN_POL);
    wire wr_bhi = wr_pend_q && (widx_q == pump_ctrl_pkg::IDX_BOOST_HI);
    wire wr_blo = wr_pend_q && (widx_q == pump_ctrl_pkg::IDX_BOOST_LO);

    wire [2:0] timer_hi = boost_gain_timer_high_q[pump_ctrl_pkg::TIMER_HI_LSB +: 3];
    wire [10:0] timer_val = {timer_hi, boost_timer_low_q};
    wire [15:0] duration = {timer_val, 5'b00000};
    wire [4:0] normal_gain = pump_gain_polarity_q[pump_ctrl_pkg::GAIN_LSB +: pump_ctrl_pkg::GAIN_W];
    wire [4:0] boost_gain = boost_gain_timer_high_q[pump_ctrl_pkg::GAIN_LSB +: pump_ctrl_pkg::GAIN_W];
    wire polarity = pump_gain_polarity_q[pump_ctrl_pkg::POL_BIT];
    wire [1:0] slip_code = div_misc_control_q[pump_ctrl_pkg::SLIP_LSB +: 2];
    wire boost_on = tif.active || (RAMP_ACTIVE && RAMP_BOOST_FLAG);

    assign tif.load = wr_fb;
    assign tif.duration = duration;
    assign tif.tick = PD_TICK;

    logic [31:0] rd_mux;
    always_comb begin
        unique case (ridx_q)
            pump_ctrl_pkg::IDX_FB_DIV: rd_mux = {16'h0000, fb_div_q};
            pump_ctrl_pkg::IDX_REF_DIV: rd_mux = {16'h0000, ref_div_q};
            pump_ctrl_pkg::IDX_DIV_MISC: rd_mux = {24'h000000, div_misc_control_q};
            pump_ctrl_pkg::IDX_GAIN_POL: rd_mux = {24'h000000, pump_gain_polarity_q};
            pump_ctrl_pkg::IDX_BOOST_HI: rd_mux = {24'h000000, boost_gain_timer_high_q};
            pump_ctrl_pkg::IDX_BOOST_LO: rd_mux = {24'h000000, boost_timer_low_q};
            pump_ctrl_pkg::IDX_STATUS: rd_mux = {15'h0000, boost_q, tif.count};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            widx_q <= 8'h00;
            ridx_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= accept && HWRITE;
            rd_wait_q <= accept && !HWRITE;
            if (accept) begin
                widx_q <= aidx;
                ridx_q <= aidx;
            end
            if (rd_wait_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            div_misc_control_q <= pump_ctrl_pkg::RST_DIV_MISC;
            pump_gain_polarity_q <= pump_ctrl_pkg::RST_GAIN_POL;
            boost_gain_timer_high_q <= pump_ctrl_pkg::RST_BOOST_HI;
            boost_timer_low_q <= pump_ctrl_pkg::RST_BOOST_LO;
            fb_div_q <= pump_ctrl_pkg::RST_FB_DIV;
            ref_div_q <= pump_ctrl_pkg::RST_REF_DIV;
        end else begin
            if (wr_misc) div_misc_control_q <= HWDATA[7:0];
            if (wr_gpol) pump_gain_polarity_q <= HWDATA[7:0];
            if (wr_bhi) boost_gain_timer_high_q <= HWDATA[7:0];
            if (wr_blo) boost_timer_low_q <= HWDATA[7:0];
            if (wr_fb) fb_div_q <= HWDATA[15:0];
            if (wr_ref) ref_div_q <= HWDATA[15:0];
        end
    end

    // Outputs to the analog side are registered so they never glitch on a decode change.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pump_gain_q <= 5'h00;
            source_q <= 1'b0;
            sink_q <= 1'b0;
            // The effective divides start at the unscaled reset divides, so reset never puts a divide of zero on a counter.
            ref_eff_q <= {2'b00, pump_ctrl_pkg::RST_REF_DIV};
            fb_eff_q <= {2'b00, pump_ctrl_pkg::RST_FB_DIV};
            boost_q <= 1'b0;
        end else begin
            boost_q <= boost_on;
            pump_gain_q <= boost_on ? boost_gain : normal_gain;
            source_q <= polarity ? FB_LEADS : REF_LEADS;
            sink_q <= polarity ? REF_LEADS : FB_LEADS;
            ref_eff_q <= pump_ctrl_pkg::scale_div(ref_div_q, boost_on ? slip_code : 2'b00);
            fb_eff_q <= pump_ctrl_pkg::scale_div(fb_div_q, boost_on ? slip_code : 2'b00);
        end
    end

    assign HRDATA = hrdata_q;
    assign HREADYOUT = !rd_wait_q;
    assign HRESP = 1'b0;
    assign PUMP_GAIN = pump_gain_q;
    assign PUMP_SOURCE = source_q;
    assign PUMP_SINK = sink_q;
    assign REF_DIV_EFF = ref_eff_q;
    assign FB_DIV_EFF = fb_eff_q;
    assign BOOST_ACTIVE = boost_q;

    property p_boost_gain;
        @(posedge CLK_SYS) disable iff (RESET)
        boost_on |=> PUMP_GAIN == $past(boost_gain) && BOOST_ACTIVE;
    endproperty
    a_boost_gain: assert property (p_boost_gain) else $error("boost gain not applied");

    property p_normal_gain;
        @(posedge CLK_SYS) disable iff (RESET)
        !boost_on |=> PUMP_GAIN == $past(normal_gain) && FB_DIV_EFF == {2'b00, $past(fb_div_q)};
    endproperty
    a_normal_gain: assert property (p_normal_gain) else $error("normal settings not restored");

    property p_polarity;
        @(posedge CLK_SYS) disable iff (RESET)
        REF_LEADS && !FB_LEADS |=> PUMP_SOURCE == !$past(polarity) && PUMP_SINK == $past(polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("pump direction wrong");

    property p_slip_x4;
        @(posedge CLK_SYS) disable iff (RESET)
        boost_on && slip_code == 2'b10 |=> REF_DIV_EFF == {$past(ref_div_q), 2'b00};
    endproperty
    a_slip_x4: assert property (p_slip_x4) else $error("reference not scaled by four");

    property p_ref_restored;
        @(posedge CLK_SYS) disable iff (RESET)
        !boost_on |=> REF_DIV_EFF == {2'b00, $past(ref_div_q)};
    endproperty
    a_ref_restored: assert property (p_ref_restored) else $error("reference scaling not removed");

    property p_slip_x2;
        @(posedge CLK_SYS) disable iff (RESET)
        boost_on && slip_code == 2'b01 |=> FB_DIV_EFF == {1'b0, $past(fb_div_q), 1'b0};
    endproperty
    a_slip_x2: assert property (p_slip_x2) else $error("feedback not scaled by two");

    property p_slip_reserved;
        @(posedge CLK_SYS) disable iff (RESET)
        boost_on && slip_code == 2'b11 |=> REF_DIV_EFF == {2'b00, $past(ref_div_q)};
    endproperty
    a_slip_reserved: assert property (p_slip_reserved) else $error("reserved slip code scaled");

    sequence s_fb_write;
        accept && HWRITE && aidx == pump_ctrl_pkg::IDX_FB_DIV;
    endsequence
    property p_fb_arms;
        @(posedge CLK_SYS) disable iff (RESET)
        s_fb_write ##1 (duration != 16'h0000) |=> tif.active ##1 BOOST_ACTIVE;
    endproperty
    a_fb_arms: assert property (p_fb_arms) else $error("divider write did not arm boost");

    sequence s_read;
        accept && !HWRITE;
    endsequence
    property p_read_wait;
        @(posedge CLK_SYS) disable iff (RESET)
        s_read |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule
`default_nettype wire

// [hw/pump_ctrl_pkg.sv]
`default_nettype none
package pump_ctrl_pkg;
    // Register indices; the AHB byte address of each is four times its index.
    localparam logic [7:0] IDX_FB_DIV = 8'h10;
    localparam logic [7:0] IDX_REF_DIV = 8'h19;
    localparam logic [7:0] IDX_DIV_MISC = 8'h1B;
    localparam logic [7:0] IDX_GAIN_POL = 8'h1C;
    localparam logic [7:0] IDX_BOOST_HI = 8'h1D;
    localparam logic [7:0] IDX_BOOST_LO = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h24;

    localparam int GAIN_LSB = 0;
    localparam int GAIN_W = 5;
    localparam int POL_BIT = 5;
    localparam int SLIP_LSB = 5;
    localparam int TIMER_HI_LSB = 5;
    localparam int TIMER_W = 11;
    localparam int DIV_W = 16;
    localparam int CNT_W = 16;
    localparam int EFF_DIV_W = 18;
    // Each timer unit lasts 32 phase-detector cycles.
    localparam int TIMER_UNIT_LOG2 = 5;

    localparam logic [7:0] RST_DIV_MISC = 8'h08;
    localparam logic [7:0] RST_GAIN_POL = 8'h00;
    localparam logic [7:0] RST_BOOST_HI = 8'h00;
    localparam logic [7:0] RST_BOOST_LO = 8'h00;
    localparam logic [15:0] RST_FB_DIV = 16'h0001;
    localparam logic [15:0] RST_REF_DIV = 16'h0001;

    typedef enum logic [1:0] {SLIP_OFF, SLIP_X2, SLIP_X4, SLIP_RSVD} slip_factor_t;
    typedef enum logic {T_IDLE, T_RUN} timer_state_t;

    function automatic logic [EFF_DIV_W-1:0] scale_div(input logic [DIV_W-1:0] div, input logic [1:0] code);
        logic [EFF_DIV_W-1:0] wide;
        wide = {2'b00, div};
        unique case (slip_factor_t'(code))
            SLIP_X2: scale_div = wide << 1;
            SLIP_X4: scale_div = wide << 2;
            SLIP_OFF, SLIP_RSVD: scale_div = wide;
        endcase
    endfunction
endpackage
`default_nettype wire

// [verif/pll_fastlock_pump_control_tb_top.sv]
`default_nettype none
module pll_fastlock_pump_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic pol;
        logic ref_l;
        logic fb_l;
        logic ramp;
        logic flag;
        logic [1:0] slip;
        logic src;
        logic snk;
        logic [4:0] gain;
        logic boost;
        logic [17:0] ref_eff;
    } row_t;
    // Reference divide is 3 throughout; the ramp rows show which slip codes scale it.
    row_t rows [6] = '{
        '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0, 5'h05, 1'h0, 18'h00003},
        '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 2'h2, 1'h0, 1'h1, 5'h05, 1'h0, 18'h00003},
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 2'h1, 1'h0, 1'h1, 5'h1F, 1'h1, 18'h00006},
        '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 2'h2, 1'h1, 1'h0, 5'h1F, 1'h1, 18'h0000C},
        '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 2'h3, 1'h1, 1'h0, 5'h1F, 1'h1, 18'h00003},
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 1'h0, 1'h1, 5'h1F, 1'h1, 18'h00003}};
    logic [7:0] ridx [7] = '{pump_ctrl_pkg::IDX_DIV_MISC, pump_ctrl_pkg::IDX_GAIN_POL, pump_ctrl_pkg::IDX_BOOST_HI,
        pump_ctrl_pkg::IDX_BOOST_LO, pump_ctrl_pkg::IDX_FB_DIV, pump_ctrl_pkg::IDX_REF_DIV, 8'h3F};
    logic [31:0] rexp [7] = '{{24'h0, pump_ctrl_pkg::RST_DIV_MISC}, {24'h0, pump_ctrl_pkg::RST_GAIN_POL},
        {24'h0, pump_ctrl_pkg::RST_BOOST_HI}, {24'h0, pump_ctrl_pkg::RST_BOOST_LO},
        {16'h0, pump_ctrl_pkg::RST_FB_DIV}, {16'h0, pump_ctrl_pkg::RST_REF_DIV}, 32'h0};
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic pd_tick = 1'h0;
    logic ramp_active = 1'h0;
    logic ramp_boost_flag = 1'h0;
    logic ref_leads = 1'h0;
    logic fb_leads = 1'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [4:0] pump_gain;
    logic pump_source;
    logic pump_sink;
    logic [17:0] ref_div_eff;
    logic [17:0] fb_div_eff;
    logic boost_active;
    int fails = 0;
    int checks = 0;

    always #2.5 clk_sys = ~clk_sys;

    pll_fastlock_pump_control pll_fastlock_pump_control_i (.CLK_SYS(clk_sys), .RESET(reset), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PD_TICK(pd_tick), .RAMP_ACTIVE(ramp_active),
        .RAMP_BOOST_FLAG(ramp_boost_flag), .REF_LEADS(ref_leads), .FB_LEADS(fb_leads), .PUMP_GAIN(pump_gain),
        .PUMP_SOURCE(pump_source), .PUMP_SINK(pump_sink), .REF_DIV_EFF(ref_div_eff), .FB_DIV_EFF(fb_div_eff),
        .BOOST_ACTIVE(boost_active));

    task automatic results;
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Sampling right after the edge sees the value the edge itself sampled.
    task automatic wait_ready;
        @(posedge clk_sys);
        while (hreadyout !== 1'h1) begin
            @(posedge clk_sys);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdv);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'h1, idx, d, x);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'h0, idx, 32'h0, x);
        chk({32'h0, x}, {32'h0, exp});
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            pd_tick <= 1'h1;
            @(posedge clk_sys);
            pd_tick <= 1'h0;
            @(posedge clk_sys);
        end
    endtask

    initial begin
        gap(3);
        reset <= 1'h0;
        @(posedge clk_sys);
        foreach (ridx[i]) rd(ridx[i], rexp[i]);
        wr(8'h3F, 32'h0000005A);
        rd(8'h3F, 32'h0);
        wr(pump_ctrl_pkg::IDX_BOOST_HI, 32'h1F);
        wr(pump_ctrl_pkg::IDX_FB_DIV, 32'h5);
        gap(3);
        chk({63'h0, boost_active}, 64'h0);
        wr(pump_ctrl_pkg::IDX_REF_DIV, 32'h3);
        foreach (rows[i]) begin
            wr(pump_ctrl_pkg::IDX_GAIN_POL, {26'h0, rows[i].pol, 5'h05});
            wr(pump_ctrl_pkg::IDX_DIV_MISC, {25'h0, rows[i].slip, 5'h08});
            ramp_active <= rows[i].ramp;
            ramp_boost_flag <= rows[i].flag;
            ref_leads <= rows[i].ref_l;
            fb_leads <= rows[i].fb_l;
            gap(3);
            chk({38'h0, pump_source, pump_sink, pump_gain, boost_active, ref_div_eff}, {38'h0, rows[i][25:0]});
        end
        ramp_active <= 1'h0;
        ramp_boost_flag <= 1'h0;
        wr(pump_ctrl_pkg::IDX_DIV_MISC, 32'h48);
        wr(pump_ctrl_pkg::IDX_BOOST_LO, 32'h0);
        wr(pump_ctrl_pkg::IDX_BOOST_HI, 32'h3F);
        wr(pump_ctrl_pkg::IDX_FB_DIV, 32'h5);
        rd(pump_ctrl_pkg::IDX_STATUS, 32'h00012000);
        wr(pump_ctrl_pkg::IDX_BOOST_LO, 32'h1);
        wr(pump_ctrl_pkg::IDX_BOOST_HI, 32'h1F);
        wr(pump_ctrl_pkg::IDX_FB_DIV, 32'h5);
        tick(20);
        wr(pump_ctrl_pkg::IDX_FB_DIV, 32'h5);
        tick(31);
        gap(3);
        chk({22'h0, boost_active, pump_gain, ref_div_eff, fb_div_eff}, {22'h0, 1'h1, 5'h1F, 18'hC, 18'h14});
        tick(1);
        gap(3);
        chk({22'h0, boost_active, pump_gain, ref_div_eff, fb_div_eff}, {22'h0, 1'h0, 5'h05, 18'h3, 18'h5});
        wr(pump_ctrl_pkg::IDX_FB_DIV, 32'h5);
        gap(2);
        chk({63'h0, boost_active}, 64'h1);
        // A reset in mid-interval must drop the boost state and return the registers to their reset values.
        reset <= 1'h1;
        gap(3);
        reset <= 1'h0;
        @(posedge clk_sys);
        chk({38'h0, hresp, hreadyout, boost_active, pump_gain, fb_div_eff},
            {38'h0, 1'h0, 1'h1, 1'h0, 5'h00, 2'h0, pump_ctrl_pkg::RST_FB_DIV});
        rd(pump_ctrl_pkg::IDX_STATUS, 32'h0);
        rd(pump_ctrl_pkg::IDX_GAIN_POL, {24'h0, pump_ctrl_pkg::RST_GAIN_POL});
        results();
    end

    initial begin
        #20000;
        fails++;
        results();
    end
endmodule
`default_nettype wire
